// File: design/ebc_area_config.sv
// External bus area configuration registers and decoded area settings.
// Assumes a synchronous Avalon-MM master and a bus controller that pulses
// i_access_start when each external access begins.
// Operation
// - Area 6 burst code: none, 4, 8, 16, 32 accesses; others reserved
// - Area 2/3 type codes 000, 010, 011, 100; other codes not settable
// - SRAM-type area 2/3 choose SRAM or multiplexed from select bit
// - Card mode bit puts areas 5, 6 on card interface, overriding others
// - Card mode turns mode pins three and four into card enable outputs
// - Width register resets on power-on only, not manual reset
// - Area 0 width captures mode pins at power-on, read-only
// - Areas 1 to 6 two-bit width fields, reset to 32 bits
// - Width register bit 1 reads zero, software writes zero
// - Port enable makes shared address/data pins a 32-bit port
// - Multiplexed select moves SRAM or burst areas 1-6 to mux interface
//
// Decided for this implementation: the Avalon-MM register port and the address map.
module ebc_area_config
   import ebc_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   input  wire logic        i_por,
   input  wire logic        i_mode_pin_three,
   input  wire logic        i_mode_pin_four,
   input  wire logic        i_access_start,
   input  wire logic [3:0]  i_address,
   input  wire logic        i_read,
   input  wire logic        i_write,
   input  wire logic [31:0] i_writedata,
   input  wire logic [3:0]  i_byteenable,
   output logic      [31:0] o_readdata,
   output logic             o_waitrequest,
   output logic             o_card_mode,
   output logic             o_card_enable2_first_sel,
   output logic             o_card_enable2_second_sel,
   output logic             o_port_function_enable,
   output logic      [2:0]  o_area6_burst_len_code,
   output logic      [13:0] o_area_iface,
   output logic      [13:0] o_area_width
);
   logic [31:0]  type_reg;
   logic [15:0]  width_reg;
   ebc_bus_t     bus_reg;
   logic [31:0]  wmask;
   logic         wr_fire;
   logic         rd_fire;
   logic [31:0]  type_next;
   logic [15:0]  width_next;
   logic [2:0]   burst_eff;
   logic [2:0]   memtype;
   logic         multiplexed_interface;
   logic         card;
   logic [13:0]  iface_next;

   // Byte lanes expanded to a bit mask
   always_comb begin
      for (int b = 0; b < 4; b++) begin
         wmask[b*8 +: 8] = {8{i_byteenable[b]}};
      end
   end

   // One wait cycle: request acknowledged on the second edge.
   // Read data loads as waitrequest drops, so it stands when sampled
   assign wr_fire = i_write && (bus_reg == BUS_ACK);
   assign rd_fire = i_read && (bus_reg == BUS_IDLE);

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         bus_reg <= BUS_IDLE;
      end else if (bus_reg == BUS_ACK) begin
         bus_reg <= BUS_IDLE;
      end else if (i_read || i_write) begin
         bus_reg <= BUS_ACK;
      end else begin
         bus_reg <= BUS_IDLE;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_waitrequest <= 1'b1;
      end else begin
         o_waitrequest <= !((i_read || i_write) && bus_reg == BUS_IDLE);
      end
   end

   // Unsettable area 2/3 codes leave the old type in place
   always_comb begin
      type_next = (type_reg & ~(TYPE_WMASK & wmask))
                | (i_writedata & TYPE_WMASK & wmask);
      case (type_next[MEMTYPE_LSB +: 3])
         MT_SRAM_SRAM, MT_SRAM_SDRAM,
         MT_SDRAM_BOTH, MT_SRAM_DRAM: begin
         end
         default: begin
            type_next[MEMTYPE_LSB +: 3] = type_reg[MEMTYPE_LSB +: 3];
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_por) begin
         type_reg <= TYPE_RESET;
      end else if (wr_fire && i_address == ADDR_TYPE_CTRL) begin
         type_reg <= type_next;
      end
   end

   // Only power-on restores widths; i_rst alone keeps them
   assign width_next = (width_reg & ~(WIDTH_WMASK & wmask[15:0]))
                     | (i_writedata[15:0] & WIDTH_WMASK & wmask[15:0]);

   always_ff @(posedge i_clk) begin
      if (i_por) begin
         width_reg <= WIDTH_RESET;
      end else if (wr_fire && i_address == ADDR_WIDTH_CTRL) begin
         width_reg <= width_next;
      end
   end

   // Mode pins caught on the edge that sees power-on held
   logic [1:0] area0_width_reg;
   always_ff @(posedge i_clk) begin
      if (i_por) begin
         area0_width_reg <= {i_mode_pin_four, i_mode_pin_three};
      end
   end

   assign card    = type_reg[CARD_BIT];
   assign multiplexed_interface     = type_reg[MPX_BIT];
   assign memtype = type_reg[MEMTYPE_LSB +: 3];
   // Card mode overrides the burst code
   assign burst_eff = card ? BST_NONE : type_reg[BURST_LSB +: 3];

   // Interface per area n at bits 2n+1:2n; area 0 is always plain SRAM.
   // Card areas show zero: the card interface has no code of its own
   for (genvar n = 0; n < 7; n++) begin : g_area
      logic [1:0] iface_area;
      always_comb begin
         iface_area = multiplexed_interface ? IF_MPX : IF_SRAM;
         if (n == 0) begin
            iface_area = IF_SRAM;
         end
         if (n == 2 && memtype == MT_SDRAM_BOTH) begin
            iface_area = IF_SDRAM;
         end
         if (n == 3) begin
            case (memtype)
               MT_SRAM_SDRAM, MT_SDRAM_BOTH: begin
                  iface_area = IF_SDRAM;
               end
               MT_SRAM_DRAM: begin
                  iface_area = IF_DRAM;
               end
               default: begin
               end
            endcase
         end
         if ((n == 5 || n == 6) && card) begin
            iface_area = IF_SRAM;
         end
      end
      assign iface_next[n*2 +: 2] = iface_area;
   end

   // Area 0 width comes from the straps; the rest from software
   logic [13:0] width_sel;
   for (genvar a = 0; a < 7; a++) begin : g_width
      if (a == 0) begin : g_strap
         assign width_sel[1:0] = area0_width_reg;
      end else begin : g_soft
         assign width_sel[a*2 +: 2] = width_reg[a*2 +: 2];
      end
   end

   // Read word built ahead so it is ready as waitrequest drops
   logic [31:0] read_word;
   always_comb begin
      case (i_address)
         ADDR_TYPE_CTRL: begin
            read_word = type_reg;
         end
         ADDR_WIDTH_CTRL: begin
            read_word = {16'h0000, area0_width_reg,
                         width_reg[13:2], 1'b0, width_reg[0]};
         end
         ADDR_STATUS: begin
            read_word = {13'h0000, o_area6_burst_len_code,
                         2'b00, o_area_iface};
         end
         default: begin
            read_word = READ_UNMAPPED;
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_readdata <= READ_UNMAPPED;
      end else if (rd_fire) begin
         o_readdata <= read_word;
      end
   end

   // Settings latched only between accesses: a write never
   // changes an access in flight, which samples at its start
   logic settings_pending_reg;
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         settings_pending_reg <= 1'b1;
      end else begin
         settings_pending_reg <= 1'b0;
      end
   end

   // Reload costs a cycle of latency but keeps every output registered
   logic reload;
   assign reload = i_access_start || settings_pending_reg;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_card_mode <= 1'b0;
      end else if (reload) begin
         o_card_mode <= card;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_card_enable2_first_sel <= 1'b0;
      end else if (reload) begin
         o_card_enable2_first_sel <= card;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_card_enable2_second_sel <= 1'b0;
      end else if (reload) begin
         o_card_enable2_second_sel <= card;
      end
   end

   // Pins stay in normal use until software sets the port enable
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_port_function_enable <= 1'b0;
      end else if (reload) begin
         o_port_function_enable <= width_reg[PORT_FUNCTION_ENABLE_BIT];
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_area6_burst_len_code <= BST_NONE;
      end else if (reload) begin
         o_area6_burst_len_code <= burst_eff;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_area_iface <= 14'h0000;
      end else if (reload) begin
         o_area_iface <= iface_next;
      end
   end

   // Reset shows 32-bit widths for areas 0 to 5 and code 00 for area 6 until the first reload
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_area_width <= WIDTH_RESET[15:2];
      end else if (reload) begin
         o_area_width <= width_sel;
      end
   end
endmodule

// File: include/ebc_pkg.sv
// Package for the external bus area configuration block.
// Assumes a single 200 MHz clock and an Avalon-MM register slave.
package ebc_pkg;
   localparam logic [3:0]  ADDR_TYPE_CTRL  = 4'h0;
   localparam logic [3:0]  ADDR_WIDTH_CTRL = 4'h4;
   localparam logic [3:0]  ADDR_STATUS     = 4'h8;
   localparam int          BURST_LSB       = 5;
   localparam int          MEMTYPE_LSB     = 2;
   localparam int          CARD_BIT        = 0;
   localparam int          MPX_BIT         = 17;
   localparam int          PORT_FUNCTION_ENABLE_BIT      = 0;
   localparam int          RSVD_BIT        = 1;
   localparam logic [31:0] TYPE_RESET      = 32'h0000_0000;
   localparam logic [31:0] TYPE_WMASK      = 32'h0002_00fd;
   localparam logic [15:0] WIDTH_RESET     = 16'h3ffc;
   localparam logic [15:0] WIDTH_WMASK     = 16'h3ffd;
   localparam logic [31:0] READ_UNMAPPED   = 32'h0000_0000;

   typedef enum logic [2:0] {
      BST_NONE = 3'b000,
      BST_4    = 3'b001,
      BST_8    = 3'b010,
      BST_16   = 3'b011,
      BST_32   = 3'b100
   } ebc_burst_t;

   typedef enum logic [2:0] {
      MT_SRAM_SRAM  = 3'b000,
      MT_SRAM_SDRAM = 3'b010,
      MT_SDRAM_BOTH = 3'b011,
      MT_SRAM_DRAM  = 3'b100
   } ebc_memtype_t;

   typedef enum logic [1:0] {
      IF_SRAM  = 2'b00,
      IF_MPX   = 2'b01,
      IF_DRAM  = 2'b10,
      IF_SDRAM = 2'b11
   } ebc_iface_t;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_ACK  = 2'b01
   } ebc_bus_t;
endpackage

// File: verif/ebc_access_model.sv
// Model of the bus controller and the mode pin straps.
// Assumes the bench asks for accesses only after width setup.
module ebc_access_model #(
   parameter logic STRAP3 = 1'b1,
   parameter logic STRAP4 = 1'b0
) (
   input  wire logic i_clk,
   input  wire logic i_go,
   output logic      o_access_start,
   output logic      o_mode_pin_three,
   output logic      o_mode_pin_four
);
   timeunit 1ns;
   timeprecision 1ps;
   assign o_mode_pin_three = STRAP3;
   assign o_mode_pin_four  = STRAP4;
   always_ff @(posedge i_clk) o_access_start <= i_go;
endmodule

// File: verif/ebc_properties.sv
// Checker for the area configuration block ports.
// Assumes one clock and the sync active-high manual reset.
module ebc_checker
   import ebc_pkg::*;
(
   input wire logic        i_clk, i_rst, i_read, i_write,
   input wire logic        i_access_start, o_waitrequest, o_card_mode,
   input wire logic        o_card_enable2_first_sel,
   input wire logic        o_card_enable2_second_sel,
   input wire logic [3:0]  i_address,
   input wire logic [31:0] o_readdata,
   input wire logic [2:0]  o_area6_burst_len_code,
   input wire logic [13:0] o_area_iface, o_area_width
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   sequence s_ask; $rose(i_read || i_write); endsequence
   sequence s_ans; !o_waitrequest ##1 o_waitrequest; endsequence
   property p_hs; s_ask |=> s_ans; endproperty
   a_hs: assert property (p_hs) else $error("bad answer timing");
   // Reload only at an access start or on the cycle after reset, so a busy access keeps its setup
   property p_stable;
      !i_access_start && !$past(i_rst) |=>
         $stable(o_area_width) && $stable(o_area_iface);
   endproperty
   a_stable: assert property (p_stable) else $error("late change");
   property p_rsvd;
      !o_waitrequest && i_read && i_address == ADDR_WIDTH_CTRL
         |-> o_readdata[31:16] == 16'h0 && !o_readdata[RSVD_BIT];
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("bit 1 set");
   property p_ce; o_card_mode |-> o_card_enable2_first_sel
      && o_card_enable2_second_sel; endproperty
   a_ce: assert property (p_ce) else $error("card enables off");
   property p_over; o_card_mode |-> o_area6_burst_len_code == 3'h0
      && o_area_iface[13:10] == 4'h0; endproperty
   a_over: assert property (p_over) else $error("no override");
   property p_bst; o_area6_burst_len_code <= 3'h4; endproperty
   a_bst: assert property (p_bst) else $error("reserved burst");
   property p_a2; o_area_iface[5:4] != IF_DRAM; endproperty
   a_a2: assert property (p_a2) else $error("area 2 dram");
   property p_a1; o_area_iface[3] == 1'b0; endproperty
   a_a1: assert property (p_a1) else $error("area 1 type");
endmodule
bind ebc_area_config ebc_checker ebc_checker_inst (.i_clk, .i_rst,
   .i_read, .i_write, .i_access_start, .o_waitrequest, .o_card_mode,
   .o_card_enable2_first_sel, .o_card_enable2_second_sel, .i_address,
   .o_readdata, .o_area6_burst_len_code, .o_area_iface, .o_area_width);

// File: verif/tb_top.sv
// Self-checking bench for the area configuration registers.
// Assumes an Avalon master with one request in flight.
module tb_top;
   import ebc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_clk = 0, i_rst = 1, i_por = 1, i_read = 0, i_write = 0, go = 0;
   logic [3:0] i_address = 4'h0;
   logic [31:0] i_writedata = 32'h0, o_readdata, rd;
   logic o_waitrequest, o_card_mode, s1, s2, pe, st, m3, m4;
   logic [2:0] bst;
   logic [13:0] o_area_iface, o_area_width;
   int fails = 0, comparisons = 0;
   logic [2:0] tbl [4] = '{3'h0, 3'h2, 3'h3, 3'h4};
   initial forever #2.5 i_clk = ~i_clk;
   ebc_access_model ebc_access_model_inst (.i_clk, .i_go(go),
      .o_access_start(st), .o_mode_pin_three(m3), .o_mode_pin_four(m4));
   ebc_area_config ebc_area_config_inst (.i_clk, .i_rst, .i_por,
      .i_mode_pin_three(m3), .i_mode_pin_four(m4), .i_access_start(st),
      .i_address, .i_read, .i_write, .i_writedata, .i_byteenable(4'hf),
      .o_readdata, .o_waitrequest, .o_card_mode,
      .o_card_enable2_first_sel(s1), .o_card_enable2_second_sel(s2),
      .o_port_function_enable(pe), .o_area6_burst_len_code(bst),
      .o_area_iface, .o_area_width);
   task automatic chk(input logic [31:0] g, e);
      comparisons++;
      if (g !== e) begin
         fails++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic acc(input logic w, input logic [3:0] a,
                      input logic [31:0] d);
      i_read <= !w;
      i_write <= w;
      i_address <= a;
      i_writedata <= d;
      do @(posedge i_clk); while (o_waitrequest !== 1'b0);
      rd = o_readdata;
      i_read <= 1'b0;
      i_write <= 1'b0;
      @(posedge i_clk);
   endtask
   task automatic kick();
      go <= 1'b1;
      @(posedge i_clk);
      go <= 1'b0;
      repeat (3) @(posedge i_clk);
   endtask
   function automatic logic [31:0] ex(input logic [2:0] t, input logic m, c);
      logic [1:0] s;
      s = m ? IF_MPX : IF_SRAM;
      return {18'h0, c ? 4'h0 : {s, s}, s,
         (t == 3'h0) ? s : (t == 3'h4) ? IF_DRAM : IF_SDRAM,
         (t == 3'h3) ? IF_SDRAM : s, s};
   endfunction
   task automatic results();
      if (fails == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge i_clk);
      fails++;
      results();
   end
   initial begin
      repeat (8) @(posedge i_clk);
      i_rst <= 1'b0;
      i_por <= 1'b0;
      @(posedge i_clk);
      acc(0, ADDR_WIDTH_CTRL, 0);
      chk(rd, 32'h7ffc);
      kick();
      chk({18'h0, o_area_width}, 32'h3ffd);
      acc(1, ADDR_WIDTH_CTRL, 32'hd557);
      chk({31'h0, pe}, 32'h0);
      kick();
      chk({31'h0, pe}, 32'h1);
      chk({18'h0, o_area_width}, 32'h1555);
      i_rst <= 1'b1;
      repeat (2) @(posedge i_clk);
      i_rst <= 1'b0;
      @(posedge i_clk);
      acc(0, ADDR_WIDTH_CTRL, 0);
      chk(rd, 32'h5555);
      for (int i = 0; i < 5; i++) begin
         acc(1, ADDR_TYPE_CTRL, 32'(i) << BURST_LSB);
         kick();
         chk({29'h0, bst}, 32'(i));
      end
      for (int j = 0; j < 8; j++) begin
         acc(1, ADDR_TYPE_CTRL, {j[2], 17'h0} | (tbl[j % 4] << 2));
         kick();
         chk({18'h0, o_area_iface[13:2], 2'h0},
             ex(tbl[j % 4], j[2], 0) << 2);
      end
      acc(1, ADDR_TYPE_CTRL, 32'h4);
      acc(0, ADDR_TYPE_CTRL, 0);
      chk(rd, 32'h10);
      acc(1, ADDR_TYPE_CTRL, 32'h0002_0001);
      kick();
      chk({18'h0, o_area_iface[13:2], 2'h0},
          ex(3'h0, 1, 1) << 2);
      chk({29'h0, o_card_mode, s1, s2}, 32'h7);
      acc(0, ADDR_STATUS, 0);
      chk(rd, 32'h154);
      acc(0, 4'hc, 0);
      chk(rd, 32'h0);
      results();
   end
endmodule
